// file: common/acr_pkg.sv
// Purpose: Shared constants and types for the converter setup word logic.
// Assumes: A 16-bit setup word reached through an 8-bit register pointer.
// Notes: Field positions, reset values and state codes for the design live here; the bench and host model repeat them as literals.
package acr_pkg;
	localparam logic [7:0] CFG_PTR = 8'h01;
	localparam logic [7:0] PTR_RESET = 8'h00;
	localparam logic [15:0] CFG_RESET = 16'h8583;
	localparam int TRIG_BIT = 15;
	localparam int PAIR_LSB = 12;
	localparam int GAIN_LSB = 9;
	localparam int MODE_BIT = 8;
	localparam int RATE_LSB = 5;
	localparam int RSV_LSB = 0;
	localparam logic [2:0] PAIR_RESET = 3'h0;
	localparam logic [2:0] GAIN_RESET = 3'h2;
	localparam logic MODE_RESET = 1'h1;
	localparam logic [2:0] RATE_RESET = 3'h4;
	localparam logic [4:0] RSV_RESET = 5'h03;
	localparam logic [2:0] GAIN_SMALLEST = 3'h5;
	localparam logic [2:0] RATE_FASTEST = 3'h6;
	localparam logic [1:0] POS_RESET = 2'h0;
	localparam logic [1:0] NEG_RESET = 2'h1;
	localparam logic [1:0] NEG_COMMON = 2'h3;
	typedef enum logic [2:0] {
		ST_PDOWN = 3'b001,
		ST_SINGLE = 3'b010,
		ST_CONT = 3'b100
	} acr_state_t;
endpackage : acr_pkg

// file: design/acr_field_decode.sv
// Purpose: Turns the stored field codes into front-end selections.
// Assumes: Fed with the next values of the setup fields, so outputs align with them.
// Notes: Aliased gain and rate codes are folded onto one code each.
`timescale 1ns/1ps
module acr_field_decode
	import acr_pkg::*;
(
	// Clock, reset and enable.
	input wire logic clock,
	input wire logic rst_b,
	input wire logic ce,
	// Field codes.
	input wire logic [2:0] pair_code,
	input wire logic [2:0] gain_code,
	input wire logic [2:0] rate_code,
	// Front-end selections.
	output logic [1:0] pos_sel_r,
	output logic [1:0] neg_sel_r,
	output logic neg_gnd_r,
	output logic [2:0] span_code_r,
	output logic [2:0] rate_sel_r
);
	logic [1:0] pos_sel_nxt;
	logic [1:0] neg_sel_nxt;
	logic neg_gnd_nxt;
	logic [2:0] span_code_nxt;
	logic [2:0] rate_sel_nxt;

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		neg_gnd_nxt = 1'b0;
		pos_sel_nxt = POS_RESET;
		neg_sel_nxt = NEG_COMMON;
		case (pair_code)
			3'h0: begin
				pos_sel_nxt = POS_RESET;
				neg_sel_nxt = NEG_RESET;
			end
			3'h1, 3'h2, 3'h3: begin
				pos_sel_nxt = 2'(pair_code - 3'h1);
			end
			default: begin
				pos_sel_nxt = pair_code[1:0];
				neg_sel_nxt = 2'h0;
				neg_gnd_nxt = 1'b1;
			end
		endcase
		span_code_nxt = (gain_code > GAIN_SMALLEST) ? GAIN_SMALLEST : gain_code;
		rate_sel_nxt = (rate_code > RATE_FASTEST) ? RATE_FASTEST : rate_code;
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			pos_sel_r <= POS_RESET;
			neg_sel_r <= NEG_RESET;
			neg_gnd_r <= 1'b0;
			span_code_r <= GAIN_RESET;
			rate_sel_r <= RATE_RESET;
		end else if (ce) begin
			pos_sel_r <= pos_sel_nxt;
			neg_sel_r <= neg_sel_nxt;
			neg_gnd_r <= neg_gnd_nxt;
			span_code_r <= span_code_nxt;
			rate_sel_r <= rate_sel_nxt;
		end
	end
endmodule : acr_field_decode

// file: design/acr_setup_word.sv
// Purpose: Holds the converter setup word and sequences single-shot and continuous runs.
// Assumes: The serial engine delivers pointer and data bytes as one-cycle strobes.
// Notes: The conversion result register is kept outside this block.
`timescale 1ns/1ps
module acr_setup_word
	import acr_pkg::*;
#(
	parameter bit HAS_MUX = 1'b1,
	parameter bit HAS_GAIN = 1'b1
) (
	// Clock, reset and enable.
	input wire logic clock,
	input wire logic rst_b,
	input wire logic ce,
	// Byte strobes from the serial engine.
	input wire logic frame_start,
	input wire logic ptr_wr,
	input wire logic byte_wr,
	input wire logic [7:0] wr_byte,
	input wire logic gc_reset,
	// Readback toward the serial engine.
	output logic [15:0] rd_word_r,
	output logic rd_cfg_sel_r,
	// Conversion sequencer.
	input wire logic conv_done,
	output logic start_r,
	output logic busy_r,
	output logic mode_single_r,
	// Analog front end.
	output logic [1:0] pos_sel_r,
	output logic [1:0] neg_sel_r,
	output logic neg_gnd_r,
	output logic [2:0] span_code_r,
	output logic [2:0] rate_sel_r
);
	function automatic logic [2:0] fix_field(input logic [2:0] code, input bit present,
		input logic [2:0] fixed);
		fix_field = present ? code : fixed;
	endfunction : fix_field

	acr_state_t state_r, state_nxt;
	logic [7:0] ptr_r, ptr_nxt;
	logic [7:0] msb_r, msb_nxt;
	logic phase_r, phase_nxt;
	logic [2:0] pair_r, pair_nxt;
	logic [2:0] gain_r, gain_nxt;
	logic mode_nxt;
	logic [2:0] rate_r, rate_nxt;
	logic [4:0] rsv_r, rsv_nxt;
	logic start_nxt, busy_nxt, rd_cfg_sel_nxt;
	logic [15:0] rd_word_nxt, cfg_word, new_word;
	logic commit;

	////////////////////////////////////////////////////////////////////////////////
	assign new_word = {msb_r, wr_byte};
	assign commit = byte_wr && phase_r && (ptr_r == CFG_PTR);
	assign cfg_word = {(state_r == ST_PDOWN), pair_r, gain_r, mode_single_r, rate_r, rsv_r};

	always_comb begin
		ptr_nxt = ptr_r;
		msb_nxt = msb_r;
		phase_nxt = phase_r;
		if (frame_start || ptr_wr) begin
			phase_nxt = 1'b0;
		end
		if (ptr_wr) begin
			ptr_nxt = wr_byte;
		end else if (byte_wr) begin
			if (!phase_r) begin
				msb_nxt = wr_byte;
			end
			phase_nxt = !phase_r;
		end
		pair_nxt = pair_r;
		gain_nxt = gain_r;
		mode_nxt = mode_single_r;
		rate_nxt = rate_r;
		rsv_nxt = rsv_r;
		if (commit) begin
			pair_nxt = fix_field(new_word[PAIR_LSB +: 3], HAS_MUX, PAIR_RESET);
			gain_nxt = fix_field(new_word[GAIN_LSB +: 3], HAS_GAIN, GAIN_RESET);
			mode_nxt = new_word[MODE_BIT];
			rate_nxt = new_word[RATE_LSB +: 3];
			rsv_nxt = new_word[RSV_LSB +: 5];
		end
		state_nxt = state_r;
		start_nxt = 1'b0;
		case (state_r)
			ST_PDOWN: begin
				if (commit && !new_word[MODE_BIT]) begin
					state_nxt = ST_CONT;
					start_nxt = 1'b1;
				end else if (commit && new_word[TRIG_BIT]) begin
					state_nxt = ST_SINGLE;
					start_nxt = 1'b1;
				end
			end
			ST_SINGLE: begin
				if (conv_done) begin
					state_nxt = mode_single_r ? ST_PDOWN : ST_CONT;
					start_nxt = !mode_single_r;
				end
			end
			ST_CONT: begin
				if (conv_done) begin
					state_nxt = mode_single_r ? ST_PDOWN : ST_CONT;
					start_nxt = !mode_single_r;
				end
			end
			default: begin
				state_nxt = ST_PDOWN;
			end
		endcase
		if (gc_reset) begin
			ptr_nxt = PTR_RESET;
			phase_nxt = 1'b0;
			pair_nxt = PAIR_RESET;
			gain_nxt = GAIN_RESET;
			mode_nxt = MODE_RESET;
			rate_nxt = RATE_RESET;
			rsv_nxt = RSV_RESET;
			state_nxt = ST_PDOWN;
			start_nxt = 1'b0;
		end
		busy_nxt = (state_nxt != ST_PDOWN);
		rd_cfg_sel_nxt = (ptr_r == CFG_PTR);
		rd_word_nxt = rd_cfg_sel_nxt ? cfg_word : 16'h0000;
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= ST_PDOWN;
			ptr_r <= PTR_RESET;
			msb_r <= 8'h00;
			phase_r <= 1'b0;
			pair_r <= PAIR_RESET;
			gain_r <= GAIN_RESET;
			mode_single_r <= MODE_RESET;
			rate_r <= RATE_RESET;
			rsv_r <= RSV_RESET;
			start_r <= 1'b0;
			busy_r <= 1'b0;
			rd_cfg_sel_r <= 1'b0;
			rd_word_r <= 16'h0000;
		end else if (ce) begin
			state_r <= state_nxt;
			ptr_r <= ptr_nxt;
			msb_r <= msb_nxt;
			phase_r <= phase_nxt;
			pair_r <= pair_nxt;
			gain_r <= gain_nxt;
			mode_single_r <= mode_nxt;
			rate_r <= rate_nxt;
			rsv_r <= rsv_nxt;
			start_r <= start_nxt;
			busy_r <= busy_nxt;
			rd_cfg_sel_r <= rd_cfg_sel_nxt;
			rd_word_r <= rd_word_nxt;
		end
	end

	acr_field_decode u_decode (
		.clock(clock),
		.rst_b(rst_b),
		.ce(ce),
		.pair_code(pair_nxt),
		.gain_code(gain_nxt),
		.rate_code(rate_nxt),
		.pos_sel_r(pos_sel_r),
		.neg_sel_r(neg_sel_r),
		.neg_gnd_r(neg_gnd_r),
		.span_code_r(span_code_r),
		.rate_sel_r(rate_sel_r)
	);

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_b);

	sequence s_single_done;
		ce && state_r == ST_SINGLE && conv_done && mode_single_r && !gc_reset;
	endsequence
	sequence s_idle_again;
		state_r == ST_PDOWN && !busy_r && !start_r;
	endsequence

	a_trig_busy_ignored: assert property ((ce && commit && state_r != ST_PDOWN && !conv_done
		&& !gc_reset) |=> !start_r && state_r == $past(state_r))
		else $error("trigger write while converting was acted on");
	a_trig_one_starts: assert property ((ce && commit && new_word[TRIG_BIT] && new_word[MODE_BIT]
		&& state_r == ST_PDOWN && !gc_reset) |=> start_r && busy_r ##1 (!ce || !start_r))
		else $error("trigger write in power-down did not start one conversion");
	a_trig_zero_idle: assert property ((ce && commit && !new_word[TRIG_BIT] && new_word[MODE_BIT]
		&& state_r == ST_PDOWN) |=> !start_r && !busy_r)
		else $error("writing zero to trigger bit changed operation");
	a_trig_readback: assert property ((ce && ptr_r == CFG_PTR) |=>
		rd_word_r[TRIG_BIT] == ($past(state_r) == ST_PDOWN) && rd_cfg_sel_r)
		else $error("trigger bit readback does not match activity");
	a_cont_reads_zero: assert property ((ce && ptr_r == CFG_PTR && state_r == ST_CONT) |=>
		!rd_word_r[TRIG_BIT])
		else $error("trigger bit read as one in continuous mode");
	a_single_returns: assert property (s_single_done |=> s_idle_again)
		else $error("single-shot did not return to power-down");
	a_pair_fixed: assert property (!HAS_MUX |-> pair_r == PAIR_RESET)
		else $error("pair field changed without multiplexer");
	a_gain_fixed: assert property (!HAS_GAIN |-> gain_r == GAIN_RESET)
		else $error("gain field changed without gain stage");
	a_word_reset: assert property ((ce && gc_reset) |=> cfg_word == CFG_RESET && !busy_r)
		else $error("setup word not at reset value after general reset");
	a_span_alias: assert property ((ce && !gc_reset && commit && HAS_GAIN
		&& new_word[GAIN_LSB +: 3] > GAIN_SMALLEST) |=> span_code_r == GAIN_SMALLEST)
		else $error("small span codes not folded together");
	a_rate_alias: assert property ((ce && !gc_reset && commit
		&& new_word[RATE_LSB +: 3] == 3'h7) |=> rate_sel_r == RATE_FASTEST)
		else $error("fastest rate codes not folded together");
endmodule : acr_setup_word

// file: verif/acr_host_model.sv
// Purpose: Host model that sends pointer and data bytes as one-cycle strobes.
// Assumes: Strobes change just after a rising edge of clock.
// Notes: The data byte shows its inverse once no strobe is up.
`timescale 1ns/1ps
module acr_host_model (
	// Clock.
	input wire logic clock,
	// Byte strobes.
	output logic frame_start,
	output logic ptr_wr,
	output logic byte_wr,
	output logic [7:0] wr_byte
);
	initial begin
		frame_start = 1'b0;
		ptr_wr = 1'b0;
		byte_wr = 1'b0;
		wr_byte = 8'h00;
	end
	task automatic send(input logic [7:0] ptr, input logic [15:0] word, input bit data);
		@(posedge clock);
		frame_start <= 1'b1;
		@(posedge clock);
		frame_start <= 1'b0;
		ptr_wr <= 1'b1;
		wr_byte <= ptr;
		if (data) begin
			@(posedge clock);
			ptr_wr <= 1'b0;
			byte_wr <= 1'b1;
			wr_byte <= word[15:8];
			@(posedge clock);
			wr_byte <= {word[7:5], 5'h03};
		end
		@(posedge clock);
		ptr_wr <= 1'b0;
		byte_wr <= 1'b0;
		wr_byte <= ~wr_byte;
	endtask : send
endmodule : acr_host_model

// file: verif/adc_config_register_tb.sv
// Purpose: Self-checking bench for the setup word logic.
// Assumes: The host model drives the byte strobes; the bench plays the sequencer.
// Notes: The model keeps the word, a busy flag and the pointer state.
`timescale 1ns/1ps
module adc_config_register_tb;
	import acr_pkg::*;
	logic clock, rst_b, ce, gc_reset, conv_done, frame_start, ptr_wr, byte_wr;
	logic [7:0] wr_byte;
	logic [15:0] rd_word_r, word_m;
	logic rd_cfg_sel_r, start_r, busy_r, mode_single_r, neg_gnd_r, busy_m, ptr_m;
	logic [1:0] pos_sel_r, neg_sel_r;
	logic [2:0] span_code_r, rate_sel_r, p, r;
	int n_errors, cmp_count, seed, i;
	acr_setup_word acr_setup_word_inst (.clock(clock), .rst_b(rst_b), .ce(ce),
		.frame_start(frame_start), .ptr_wr(ptr_wr), .byte_wr(byte_wr), .wr_byte(wr_byte),
		.gc_reset(gc_reset), .rd_word_r(rd_word_r), .rd_cfg_sel_r(rd_cfg_sel_r),
		.conv_done(conv_done), .start_r(start_r), .busy_r(busy_r), .mode_single_r(mode_single_r),
		.pos_sel_r(pos_sel_r), .neg_sel_r(neg_sel_r), .neg_gnd_r(neg_gnd_r),
		.span_code_r(span_code_r), .rate_sel_r(rate_sel_r));
	acr_host_model acr_host_model_inst (.clock(clock), .frame_start(frame_start),
		.ptr_wr(ptr_wr), .byte_wr(byte_wr), .wr_byte(wr_byte));
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic check_all();
		repeat (2) @(posedge clock);
		#1;
		p = word_m[14:12];
		chk("readback", ptr_m ? {~busy_m, word_m[14:0]} : 16'h0000, rd_word_r);
		chk("cfg select", 16'(ptr_m), 16'(rd_cfg_sel_r));
		chk("busy", 16'(busy_m), 16'(busy_r));
		chk("mode", 16'(word_m[8]), 16'(mode_single_r));
		chk("pos", p[2] ? 16'(p[1:0]) : 16'(p - 3'(p != 3'h0)), 16'(pos_sel_r));
		chk("neg", p[2] ? 16'h0 : (p == 3'h0 ? 16'h1 : 16'h3), 16'(neg_sel_r));
		chk("ground", 16'(p[2]), 16'(neg_gnd_r));
		chk("span", word_m[11:9] > 3'h5 ? 16'h5 : 16'(word_m[11:9]), 16'(span_code_r));
		chk("rate", word_m[7:5] > 3'h6 ? 16'h6 : 16'(word_m[7:5]), 16'(rate_sel_r));
	endtask : check_all
	task automatic starts(input int exp);
		int seen;
		seen = 0;
		repeat (3) begin
			#1;
			if (start_r === 1'b1) seen++;
			@(posedge clock);
		end
		chk("starts", 16'(exp), 16'(seen));
	endtask : starts
	task automatic wr(input logic [15:0] w);
		int go;
		acr_host_model_inst.send(CFG_PTR, w, 1'b1);
		go = !busy_m && (w[15] || !w[8]);
		word_m = {1'b0, w[14:5], 5'h03};
		busy_m = busy_m || (go != 0);
		ptr_m = 1'b1;
		starts(go);
	endtask : wr
	task automatic done();
		int go;
		@(posedge clock);
		conv_done <= 1'b1;
		@(posedge clock);
		conv_done <= 1'b0;
		go = busy_m && !word_m[8];
		busy_m = (go != 0);
		starts(go);
	endtask : done
	task automatic conclude();
		$display("counts: %0d compares, %0d mismatches", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : conclude
	initial begin
		rst_b = 1'b0;
		ce = 1'b1;
		gc_reset = 1'b0;
		conv_done = 1'b0;
		n_errors = 0;
		cmp_count = 0;
		seed = 32'h14a8348f;
		word_m = CFG_RESET;
		busy_m = 1'b0;
		ptr_m = 1'b0;
		repeat (8) @(posedge clock);
		rst_b <= 1'b1;
		acr_host_model_inst.send(CFG_PTR, 16'h0000, 1'b0);
		ptr_m = 1'b1;
		check_all();
		$display("test reset done");
		r = 3'($random(seed));
		for (i = 0; i < 8; i++) begin
			wr({1'b0, i[2:0], i[2:0] ^ r, 1'b1, i[2:0] ^ ~r, 5'h03});
			check_all();
		end
		$display("test fields done");
		wr(CFG_RESET);
		check_all();
		wr(CFG_RESET);
		done();
		check_all();
		$display("test single done");
		wr(16'h0483);
		check_all();
		done();
		wr(16'h0583);
		done();
		check_all();
		$display("test continuous done");
		@(posedge clock);
		ce <= 1'b0;
		acr_host_model_inst.send(8'h00, 16'h0000, 1'b0);
		ce <= 1'b1;
		check_all();
		$display("test clock enable done");
		@(posedge clock);
		gc_reset <= 1'b1;
		@(posedge clock);
		gc_reset <= 1'b0;
		word_m = CFG_RESET;
		ptr_m = 1'b0;
		check_all();
		acr_host_model_inst.send(CFG_PTR, 16'h0000, 1'b0);
		ptr_m = 1'b1;
		check_all();
		$display("test general reset done");
		conclude();
	end
endmodule : adc_config_register_tb
